// >>> rtl/chsf_cfg.svh
// Charger serial port and fault report: shared constants.
// Assumes a 40 MHz core clock; the analog side supplies level events on it.
`ifndef CHSF_CFG_SVH
`define CHSF_CFG_SVH
`define CHSF_CLK_MHZ 40
`define CHSF_SLV_ADDR 7'h6A
`define CHSF_HANG_US 25000
`define CHSF_HANG_CYC (`CHSF_HANG_US * `CHSF_CLK_MHZ)
`define CHSF_INT_US 128
`define CHSF_INT_CYC (`CHSF_INT_US * `CHSF_CLK_MHZ)
`define CHSF_BYTE_BITS 4'h8
`define CHSF_IDX_STAT 8'h00
`define CHSF_IDX_FLT 8'h01
`define CHSF_RD_UNMAP 8'hFF
`define CHSF_AV_CTRL 2'h0
`define CHSF_AV_STAT 2'h1
`define CHSF_AV_IDX 2'h2
`endif

// >>> rtl/chsf_if.sv
// Link between the serial engine and the status block.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface chsf_if;
    logic       uv_clr, mask_we, inhibit;
    logic [3:0] mask_wd;
    logic [7:0] stat_byte, fault_byte;
    logic [2:0] ts_field;
    modport eng (output uv_clr, mask_we, inhibit, mask_wd,
                 input stat_byte, fault_byte, ts_field);
    modport sts (input uv_clr, mask_we, inhibit, mask_wd,
                 output stat_byte, fault_byte, ts_field);
endinterface : chsf_if

// >>> rtl/chsf_pkg.sv
// Charger serial port and fault report: shared types.
// Assumes chsf_cfg.svh for all numeric constants.
package chsf_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ACKA = 3'h3, ST_WRX = 3'h2,
        ST_ACKW = 3'h6, ST_TXB = 3'h7, ST_ACKR = 3'h5, ST_WAIT = 3'h4
    } chsf_state_type;
    typedef enum logic [1:0] {
        CS_READY = 2'h0, CS_PROG = 2'h1, CS_DONE = 2'h2, CS_FAULT = 2'h3
    } chsf_stat_type;
    typedef enum logic [2:0] {
        TS_NONE = 3'h0, TS_COLD = 3'h1, TS_HOT = 3'h2, TS_COOL = 3'h3, TS_WARM = 3'h4
    } chsf_ts_type;
    typedef struct packed {
        chsf_state_type st;
        logic [3:0]     cnt;
        logic [7:0]     sh, tx, idx;
        logic           first, rw, nack, oe, run;
        logic [19:0]    hang;
        logic           scl_d, sda_d, uv_clr, mask_we, inhibit, av_ack;
        logic [3:0]     mask_wd;
        logic [31:0]    av_rd;
    } chsf_eng_type;
    typedef struct packed {
        logic [6:0]     prev;
        chsf_ts_type    ts;
        logic           ov, uv, tmr, buv, vdpm, done, lim;
        logic [3:0]     mask;
        logic [12:0]    icnt;
        logic           int_o, pg, chg, half, drop;
        chsf_stat_type  stat;
    } chsf_sts_type;
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] q;
    } chsf_sync_type;
endpackage : chsf_pkg

// >>> rtl/chsf_status.sv
// Fault and status tracking with interrupt pulse and charger steering.
// Assumes event inputs are level signals already on the core clock.
`timescale 1ns/1ps
`include "chsf_cfg.svh"
module chsf_status #(
    parameter int INT_CYC = `CHSF_INT_CYC // interrupt pulse length
) (
    input  wire logic     clk,       // core clock
    input  wire logic     rstn,      // async reset, active low
    input  wire logic [6:0] ev,      // ov uv lim tmr vdpm done buv
    input  wire logic     rchg,      // battery below recharge threshold
    input  wire chsf_pkg::chsf_ts_type ts_zone, // thermistor zone
    chsf_if.sts           bus,       // engine side
    output logic          int_o,     // interrupt pulse
    output logic          pg,        // power good
    output logic          chg,       // charger enable
    output logic          lim,       // input current limited
    output logic          half,      // charge current halved
    output logic          drop       // regulation target lowered
);
    import chsf_pkg::*;
    chsf_sts_type r, n;
    logic [6:0] rise;
    logic       irq;
    assign rise = ev & ~r.prev;
    // masked faults still update flags, they only stay off the pin
    assign irq = (rise[6] & ~r.mask[3]) | (rise[5] & ~r.mask[2])
               | (rise[0] & ~r.mask[1]) | (|rise[4:1])
               | ((ts_zone != r.ts) && (ts_zone != TS_NONE));
    always_comb begin
        n = r;
        n.prev = ev;
        n.ts = ts_zone;
        n.ov = ev[6];
        n.lim = ev[4];
        n.vdpm = ev[2];
        n.buv = ev[0];
        n.uv = rise[5] | (r.uv & ~bus.uv_clr);
        n.tmr = r.tmr | rise[3];
        n.done = rise[1] | (r.done & ~rchg);
        if (bus.mask_we) n.mask = bus.mask_wd;
        if (irq) n.icnt = 13'(INT_CYC);
        else if (r.icnt != 13'h0) n.icnt = r.icnt - 13'h1;
        n.int_o = (n.icnt != 13'h0);
        n.pg = ~(ev[6] | ev[5]);
        n.chg = ~bus.inhibit & n.pg & ~n.tmr & ~n.done
              & (ts_zone != TS_COLD) & (ts_zone != TS_HOT);
        n.half = (ts_zone == TS_COOL);
        n.drop = (ts_zone == TS_WARM);
        if (ev[6] | n.tmr | ev[0] | ev[2] | (ts_zone != TS_NONE)) n.stat = CS_FAULT;
        else if (n.done) n.stat = CS_DONE;
        else if (n.chg) n.stat = CS_PROG;
        else n.stat = CS_READY;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) r <= '0;
        else r <= n;
    end
    assign bus.stat_byte = {r.stat, 3'h0, r.tmr, r.vdpm, 1'b0};
    assign bus.fault_byte = {r.ov, r.uv, r.buv, 1'b0, r.mask};
    assign bus.ts_field = r.ts;
    assign {int_o, pg, chg, lim, half, drop} = {r.int_o, r.pg, r.chg, r.lim, r.half, r.drop};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_UV_ONCE: assert property (r.uv && bus.uv_clr && !rise[5] |=> !r.uv)
        else $error("undervoltage flag survived its read");
    AST_OV_FAULT: assert property (ev[6] |=> r.stat == CS_FAULT && !r.pg && !r.chg)
        else $error("overvoltage not reported as fault");
    AST_TMR_FAULT: assert property (rise[3] |=> r.tmr && r.stat == CS_FAULT && !r.chg)
        else $error("timer expiry not reported");
    AST_INT_PULSE: assert property (irq |=> r.int_o [*8])
        else $error("interrupt pulse too short");
    AST_COOL: assert property (ts_zone == TS_COOL |=> r.half && r.stat == CS_FAULT)
        else $error("cool zone not handled");
    AST_WARM: assert property (ts_zone == TS_WARM |=> r.drop && r.stat == CS_FAULT)
        else $error("warm zone not handled");
endmodule : chsf_status

// >>> rtl/chsf_sync.sv
// Two-flop synchroniser for the serial clock and data pins.
// Assumes idle-high pins, so reset loads ones.
`timescale 1ns/1ps
module chsf_sync (
    input  wire logic       clk,  // core clock
    input  wire logic       rstn, // async reset, active low
    input  wire logic [1:0] d,    // raw pin levels
    output logic      [1:0] q     // synchronised levels
);
    import chsf_pkg::*;
    chsf_sync_type r, n;
    always_comb begin
        n = r;
        n.meta = d;
        n.q = r.meta;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) r <= '1;
        else r <= n;
    end
    assign q = r.q;
endmodule : chsf_sync

// >>> rtl/chsf_top.sv
// Charger host serial port: two-wire slave engine and Avalon-MM register port.
// Assumes SCL and SDA arrive from outside the MCLK domain; events share MCLK.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "chsf_cfg.svh"
module chsf_top #(
    parameter int HANG_CYC = `CHSF_HANG_CYC, // bus hang timeout in cycles
    parameter int INT_CYC  = `CHSF_INT_CYC   // interrupt pulse in cycles
) (
    input  wire logic        MCLK,            // core clock
    input  wire logic        RSTN,            // async reset, active low
    input  wire logic        SCL_IN,          // serial clock pin
    input  wire logic        SDA_IN,          // serial data pin
    output logic             SDA_OUT,         // serial data drive level
    output logic             SDA_OE,          // serial data drive enable
    input  wire logic [1:0]  AVS_ADDRESS,     // word address
    input  wire logic        AVS_READ,        // read request
    input  wire logic        AVS_WRITE,       // write request
    input  wire logic [31:0] AVS_WRITEDATA,   // write data
    output logic      [31:0] AVS_READDATA,    // read data
    output logic             AVS_WAITREQUEST, // stall
    input  wire logic        OV_DET,          // input overvoltage
    input  wire logic        UV_DET,          // input undervoltage
    input  wire logic        LIMIT_DET,       // input current limit active
    input  wire logic        TMR_DET,         // safety timer expired
    input  wire logic        VDPM_DET,        // input voltage loop active
    input  wire logic        DONE_DET,        // charge complete
    input  wire logic        BUV_DET,         // battery low lockout
    input  wire logic        RCHG_DET,        // battery below recharge level
    input  wire chsf_pkg::chsf_ts_type TS_ZONE, // thermistor zone
    output logic             INT_PULSE,       // host interrupt pulse
    output logic             POWER_GOOD,      // input power good
    output logic             CHG_EN,          // charger enable
    output logic             IN_LIMIT,        // charging at limited input
    output logic             CUR_HALF,        // charge current halved
    output logic             VREG_DROP        // target lowered by 140 mV
);
    import chsf_pkg::*;

    // ************************************************************
    // pins and status block
    // ************************************************************
    chsf_if       bus ();
    chsf_eng_type r, n;
    logic [1:0]   pin_s;
    logic         scl, sda, scl_rise, scl_fall;
    logic         start, stop, hang_out, req, ld;
    logic [7:0]   ld_byte;

    chsf_sync u_sync (
        .clk  (MCLK),
        .rstn (RSTN),
        .d    ({SCL_IN, SDA_IN}),
        .q    (pin_s)
    );

    chsf_status #(
        .INT_CYC (INT_CYC)
    ) u_status (
        .clk     (MCLK),
        .rstn    (RSTN),
        .ev      ({OV_DET, UV_DET, LIMIT_DET, TMR_DET, VDPM_DET, DONE_DET, BUV_DET}),
        .rchg    (RCHG_DET),
        .ts_zone (TS_ZONE),
        .bus     (bus),
        .int_o   (INT_PULSE),
        .pg      (POWER_GOOD),
        .chg     (CHG_EN),
        .lim     (IN_LIMIT),
        .half    (CUR_HALF),
        .drop    (VREG_DROP)
    );

    // edges come from oversampling, so any rate up to 400k works alike
    assign scl = pin_s[1];
    assign sda = pin_s[0];
    assign scl_rise = scl & ~r.scl_d;
    assign scl_fall = ~scl & r.scl_d;
    assign start = scl & r.scl_d & r.sda_d & ~sda;
    assign stop = scl & r.scl_d & ~r.sda_d & sda;
    assign hang_out = r.run & ~sda & (r.hang == 20'(HANG_CYC - 1));
    assign req = AVS_READ | AVS_WRITE;

    function automatic logic [7:0] chsf_rd_byte(input logic [7:0] idx,
                                                input logic [7:0] s,
                                                input logic [7:0] f);
        case (idx)
            `CHSF_IDX_STAT: return s;
            `CHSF_IDX_FLT:  return f;
            default:        return `CHSF_RD_UNMAP;
        endcase
    endfunction : chsf_rd_byte

    assign ld_byte = chsf_rd_byte(r.idx, bus.stat_byte, bus.fault_byte);

    // ************************************************************
    // engine
    // ************************************************************
    always_comb begin
        n = r;
        ld = 1'b0;
        n.scl_d = scl;
        n.sda_d = sda;
        n.uv_clr = 1'b0;
        n.mask_we = 1'b0;
        n.av_ack = 1'b0;
        // one wait cycle, then answer; write lands on the answering edge
        if (req && !r.av_ack) begin
            n.av_ack = 1'b1;
            case (AVS_ADDRESS)
                `CHSF_AV_CTRL: n.av_rd = {31'h0, r.inhibit};
                `CHSF_AV_STAT: n.av_rd = {12'h0, bus.ts_field, r.run,
                                          bus.fault_byte, bus.stat_byte};
                `CHSF_AV_IDX:  n.av_rd = {24'h0, r.idx};
                default:       n.av_rd = 32'h0;
            endcase
        end
        if (r.av_ack && AVS_WRITE && AVS_ADDRESS == `CHSF_AV_CTRL) begin
            n.inhibit = AVS_WRITEDATA[0];
        end
        n.hang = (r.run && !sda) ? r.hang + 20'h1 : 20'h0;
        if (start) begin
            n.st = ST_ADDR;
            n.cnt = 4'h0;
            n.oe = 1'b0;
            n.run = 1'b1;
            n.hang = 20'h0;
        end else if (stop) begin
            n.st = ST_IDLE;
            n.oe = 1'b0;
            n.run = 1'b0;
            n.hang = 20'h0;
        end else if (hang_out) begin
            // nothing more is taken until a fresh START
            n.st = ST_IDLE;
            n.oe = 1'b0;
            n.run = 1'b0;
            n.hang = 20'h0;
        end else begin
            case (r.st)
                ST_ADDR, ST_WRX: begin
                    if (scl_rise) begin
                        n.sh = {r.sh[6:0], sda};
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == `CHSF_BYTE_BITS) begin
                        if (r.st == ST_ADDR) begin
                            if (r.sh[7:1] == `CHSF_SLV_ADDR) begin
                                n.oe = 1'b1;
                                n.rw = r.sh[0];
                                n.st = ST_ACKA;
                            end else begin
                                n.st = ST_WAIT;
                            end
                        end else begin
                            n.oe = 1'b1;
                            n.st = ST_ACKW;
                            n.first = 1'b0;
                            if (r.first) begin
                                n.idx = r.sh;
                            end else begin
                                n.idx = r.idx + 8'h01;
                                n.mask_we = (r.idx == `CHSF_IDX_FLT);
                                n.mask_wd = r.sh[3:0];
                            end
                        end
                    end
                end
                ST_ACKA: begin
                    if (scl_fall) begin
                        if (r.rw) begin
                            ld = 1'b1;
                        end else begin
                            n.oe = 1'b0;
                            n.st = ST_WRX;
                            n.cnt = 4'h0;
                            n.first = 1'b1;
                        end
                    end
                end
                ST_ACKW: begin
                    if (scl_fall) begin
                        n.oe = 1'b0;
                        n.st = ST_WRX;
                        n.cnt = 4'h0;
                    end
                end
                ST_TXB: begin
                    if (scl_rise) begin
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (r.cnt == `CHSF_BYTE_BITS) begin
                            n.oe = 1'b0;
                            n.st = ST_ACKR;
                        end else begin
                            n.tx = {r.tx[6:0], 1'b1};
                            n.oe = ~r.tx[6];
                        end
                    end
                end
                ST_ACKR: begin
                    if (scl_rise) begin
                        n.nack = sda;
                    end else if (scl_fall) begin
                        if (r.nack) n.st = ST_WAIT;
                        else ld = 1'b1;
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    n.oe = 1'b0;
                end
                default: begin
                    n.st = ST_IDLE;
                    n.oe = 1'b0;
                end
            endcase
        end
        if (ld) begin
            n.tx = ld_byte;
            n.oe = ~ld_byte[7];
            n.idx = r.idx + 8'h01;
            n.cnt = 4'h0;
            n.st = ST_TXB;
            n.uv_clr = (r.idx == `CHSF_IDX_FLT);
        end
    end

    // pins idle high, so edge history starts high: no false edge after reset
    localparam chsf_eng_type ENG_RESET = '{st: ST_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) r <= ENG_RESET;
        else r <= n;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign SDA_OUT = 1'b0;
    assign SDA_OE = r.oe;
    assign AVS_READDATA = r.av_rd;
    assign AVS_WAITREQUEST = req & ~r.av_ack;
    assign bus.uv_clr = r.uv_clr;
    assign bus.mask_we = r.mask_we;
    assign bus.mask_wd = r.mask_wd;
    assign bus.inhibit = r.inhibit;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    sequence s_quiet;
        !start && !stop && !hang_out;
    endsequence
    sequence s_addr_done;
        r.st == ST_ADDR && scl_fall && r.cnt == `CHSF_BYTE_BITS ##0 s_quiet;
    endsequence
    sequence s_data_done;
        r.st == ST_WRX && scl_fall && r.cnt == `CHSF_BYTE_BITS ##0 s_quiet;
    endsequence

    AST_ADDR_ACK: assert property (s_addr_done ##0 r.sh[7:1] == `CHSF_SLV_ADDR
        |=> r.oe && r.st == ST_ACKA)
        else $error("own address not acknowledged");
    AST_ADDR_IGN: assert property (s_addr_done ##0 r.sh[7:1] != `CHSF_SLV_ADDR
        |=> !r.oe && r.st == ST_WAIT)
        else $error("foreign address acknowledged");
    AST_ACK_HOLD: assert property (r.st == ST_ACKA && !scl_fall ##0 s_quiet |=> r.oe)
        else $error("acknowledge released early");
    AST_DIR: assert property (s_addr_done ##0 r.sh[7:1] == `CHSF_SLV_ADDR
        |=> r.rw == $past(r.sh[0]))
        else $error("direction bit lost");
    AST_START: assert property (start |=> r.st == ST_ADDR && r.run && r.hang == 20'h0)
        else $error("start not taken");
    AST_STOP: assert property (stop |=> r.st == ST_IDLE && !r.oe && !r.run)
        else $error("stop did not release the bus");
    AST_HANG: assert property (hang_out && !start && !stop
        |=> r.st == ST_IDLE && !r.run && !r.oe)
        else $error("hang timeout did not reset engine");
    AST_HANG_CNT: assert property (r.run && !sda ##0 s_quiet ##1 !sda && r.run
        |-> r.hang == $past(r.hang) + 20'h1)
        else $error("hang timer not counting");
    AST_DATA_ACK: assert property (s_data_done |=> r.st == ST_ACKW && r.oe)
        else $error("data byte not acknowledged");
    AST_INDEX: assert property (s_data_done ##0 r.first
        |=> r.idx == $past(r.sh) && !r.first)
        else $error("index byte not stored");
    AST_UNMAP: assert property (r.st == ST_TXB && $past(r.st) != ST_TXB
        && $past(r.idx) > `CHSF_IDX_FLT |-> r.tx == `CHSF_RD_UNMAP)
        else $error("unlisted index did not read FF");
    AST_AV_ANSWER: assert property (req && !r.av_ack |=> !AVS_WAITREQUEST)
        else $error("register port did not answer");
    AST_AV_WRITE: assert property (r.av_ack && AVS_WRITE && AVS_ADDRESS == `CHSF_AV_CTRL
        |=> r.inhibit == $past(AVS_WRITEDATA[0]))
        else $error("control write did not land");
    AST_ACKW_REL: assert property (r.st == ST_ACKW && scl_fall ##0 s_quiet
        |=> !r.oe && r.st == ST_WRX)
        else $error("write acknowledge not released");
    AST_NACK_END: assert property (r.st == ST_ACKR && scl_fall && r.nack ##0 s_quiet
        |=> r.st == ST_WAIT && !r.oe)
        else $error("device kept sending after master refusal");
    AST_TX_LOAD: assert property (ld |=> r.st == ST_TXB && r.oe == !$past(ld_byte[7]))
        else $error("first read bit not driven");
    AST_TX_SHIFT: assert property (r.st == ST_TXB && scl_fall
        && r.cnt != `CHSF_BYTE_BITS ##0 s_quiet |=> r.oe == !$past(r.tx[6]))
        else $error("read bit not shifted out");
    AST_TX_HOLD: assert property (r.st == ST_TXB && !scl_fall ##0 s_quiet
        |=> $stable(r.oe))
        else $error("read bit changed outside clock low");
    AST_UV_CLR: assert property (ld && r.idx == `CHSF_IDX_FLT |=> r.uv_clr)
        else $error("fault byte read did not clear undervoltage");
    AST_MASK_WR: assert property (s_data_done ##0 !r.first && r.idx == `CHSF_IDX_FLT
        |=> r.mask_we && r.mask_wd == $past(r.sh[3:0]))
        else $error("mask write not passed on");
    AST_IDLE_QUIET: assert property ((r.st == ST_IDLE || r.st == ST_WAIT) && !start
        |=> !r.oe)
        else $error("data line driven while idle");
endmodule : chsf_top

// >>> test/chsf_host.sv
// Serial bus master model: drives SCL and the master half of SDA.
// Assumes the bench resolves the open-drain SDA wire with a pull-up.
`timescale 1ns/1ps
module chsf_host (
    output logic      SCL = 1'b1,   // serial clock, held high between frames
    output logic      M_SDA = 1'b1, // master data drive, 1 releases the line
    input  wire logic SDA           // resolved bus level
);
    task automatic start();
        #100 M_SDA = 1'b1;
        #100 SCL = 1'b1;
        #100 M_SDA = 1'b0;
        #100 SCL = 1'b0;
    endtask : start
    task automatic stop();
        #100 M_SDA = 1'b0;
        #100 SCL = 1'b1;
        #100 M_SDA = 1'b1;
        #100;
    endtask : stop
    // long low phase so a late ack release never looks like a stop
    task automatic one(input logic d, output logic r);
        #60 M_SDA = d;
        #60 SCL = 1'b1;
        #40 r = SDA;
        #40 SCL = 1'b0;
    endtask : one
    task automatic xb(input logic [7:0] d, input logic ai,
                      output logic [7:0] q, output logic ao);
        for (int i = 7; i >= 0; i--) one(d[i], q[i]);
        one(ai, ao);
    endtask : xb
endmodule : chsf_host

// >>> test/chsf_top_tb.sv
// Self-checking bench for the charger serial port and status block.
// Assumes chsf_host as serial master and an idle-high open-drain SDA.
`timescale 1ns/1ps
module chsf_top_tb;
    import chsf_pkg::*;
    logic MCLK = 1'b0, RSTN = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, SCL, m_sda, a;
    logic [1:0] AVS_ADDRESS = 2'h0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
    logic OV_DET = 1'b0, UV_DET = 1'b0, LIMIT_DET = 1'b0, TMR_DET = 1'b0, VDPM_DET = 1'b0;
    logic DONE_DET = 1'b0, BUV_DET = 1'b0, RCHG_DET = 1'b0, SDA_OUT, SDA_OE, AVS_WAITREQUEST;
    logic INT_PULSE, POWER_GOOD, CHG_EN, IN_LIMIT, CUR_HALF, VREG_DROP;
    logic [7:0] b;
    logic [3:0] m;
    chsf_ts_type TS_ZONE = TS_NONE;
    int n_errors = 0, checked = 0;
    wire sda = m_sda & ~SDA_OE;
    always #12.5 MCLK = ~MCLK;
    chsf_host u_host (.SCL, .M_SDA(m_sda), .SDA(sda));
    chsf_top #(.HANG_CYC(200), .INT_CYC(16)) u_dut (.MCLK, .RSTN, .SCL_IN(SCL), .SDA_IN(sda),
        .SDA_OUT, .SDA_OE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA,
        .AVS_WAITREQUEST, .OV_DET, .UV_DET, .LIMIT_DET, .TMR_DET, .VDPM_DET, .DONE_DET,
        .BUV_DET, .RCHG_DET, .TS_ZONE, .INT_PULSE, .POWER_GOOD, .CHG_EN, .IN_LIMIT,
        .CUR_HALF, .VREG_DROP);
    task automatic stop_test();
        if (n_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic av(input logic wr, input logic [1:0] ad, input logic [31:0] d);
        @(posedge MCLK);
        AVS_ADDRESS <= ad;
        AVS_WRITEDATA <= d;
        AVS_READ <= ~wr;
        AVS_WRITE <= wr;
        do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask : av
    task automatic stat(input logic [1:0] s, input logic c);
        repeat (3) @(posedge MCLK);
        av(1'b0, 2'h1, 32'h0);
        chk(q[7:6], s);
        chk(CHG_EN, c);
    endtask : stat
    task automatic rd(input logic [7:0] ix);
        u_host.start();
        u_host.xb(8'hD4, 1'b1, b, a);
        chk(a, 1'b0);
        u_host.xb(ix, 1'b1, b, a);
        u_host.start();
        u_host.xb(8'hD5, 1'b1, b, a);
        chk(a, 1'b0);
        u_host.xb(8'hFF, 1'b1, b, a);
        u_host.stop();
    endtask : rd
    initial begin
        void'($urandom(32'h9A32));
        repeat (8) @(posedge MCLK);
        RSTN <= 1'b1;
        av(1'b1, 2'h0, 32'h1);
        av(1'b0, 2'h0, 32'h0);
        chk(q, 32'h1);
        stat(2'h0, 1'b0);
        av(1'b1, 2'h0, 32'h0);
        stat(2'h1, 1'b1);
        av(1'b1, 2'h3, 32'hFFFF_FFFF);
        av(1'b0, 2'h3, 32'h0);
        chk(q, 32'h0);
        m = 4'($urandom) & 4'h7;
        u_host.start();
        u_host.xb(8'hD4, 1'b1, b, a);
        u_host.xb(8'h01, 1'b1, b, a);
        u_host.xb({4'h0, m}, 1'b1, b, a);
        chk(a, 1'b0);
        u_host.stop();
        av(1'b0, 2'h2, 32'h0);
        chk(q, 32'h2);
        chk(SDA_OUT, 1'b0);
        rd(8'h01);
        chk(b, {4'h0, m});
        rd(8'h02 + 8'($urandom % 252));
        chk(b, 8'hFF);
        u_host.start();
        u_host.xb(8'hD4 ^ (8'h02 << ($urandom % 7)), 1'b1, b, a);
        chk(a, 1'b1);
        u_host.stop();
        // sda held low past the hang limit, then an address that must be ignored
        u_host.start();
        #6000;
        u_host.xb(8'hD4, 1'b1, b, a);
        chk(a, 1'b1);
        u_host.stop();
        rd(8'h00);
        @(posedge MCLK);
        OV_DET <= 1'b1;
        stat(2'h3, 1'b0);
        chk(POWER_GOOD, 1'b0);
        chk(INT_PULSE, 1'b1);
        OV_DET <= 1'b0;
        UV_DET <= 1'b1;
        stat(2'h0, 1'b0);
        chk(POWER_GOOD, 1'b0);
        UV_DET <= 1'b0;
        rd(8'h01);
        chk(b[6], 1'b1);
        rd(8'h01);
        chk(b[6], 1'b0);
        @(posedge MCLK);
        LIMIT_DET <= 1'b1;
        stat(2'h1, 1'b1);
        chk(IN_LIMIT, 1'b1);
        chk(INT_PULSE, 1'b1);
        LIMIT_DET <= 1'b0;
        DONE_DET <= 1'b1;
        stat(2'h2, 1'b0);
        RCHG_DET <= 1'b1;
        for (int z = 1; z < 5; z++) begin
            TS_ZONE <= chsf_ts_type'(z);
            stat(2'h3, z > 2);
            chk(q[19:17], z);
            chk(CUR_HALF, z == 3);
            chk(VREG_DROP, z == 4);
        end
        TS_ZONE <= TS_NONE;
        TMR_DET <= 1'b1;
        stat(2'h3, 1'b0);
        rd(8'h00);
        chk(b, 8'hC4);
        stop_test();
    end
    initial begin
        #400_000;
        n_errors++;
        stop_test();
    end
endmodule : chsf_top_tb
